// ### core/lsc_pkg.sv
// line correction constants: register map, fields, resets
// assumes a 125 MHz system clock and a 32-bit Avalon-MM register port
package lsc_pkg;

    // register word addresses
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_GOALS    = 4'h1;
    localparam logic [3:0] REG_REGION   = 4'h2;
    localparam logic [3:0] REG_EDGE     = 4'h3;
    localparam logic [3:0] REG_PARALLAX = 4'h4;
    localparam logic [3:0] REG_RATE     = 4'h5;
    localparam logic [3:0] REG_OFF_ADDR = 4'h6;
    localparam logic [3:0] REG_OFF_DATA = 4'h7;
    localparam logic [3:0] REG_STATUS   = 4'h8;

    // control register fields
    localparam int CTRL_OFF_USE   = 0;
    localparam int CTRL_GAIN_USE  = 1;
    localparam int CTRL_MANUAL    = 2;
    localparam int CTRL_SMOOTH    = 3;
    localparam int CTRL_REGION_ON = 4;
    localparam int CTRL_EDGE_ON   = 5;
    localparam int CTRL_COLOUR    = 6;
    localparam int CTRL_SET_LSB   = 8;
    localparam int CTRL_ACTIVATE  = 31;

    // status register fields
    localparam int STAT_CAL_BUSY  = 0;
    localparam int STAT_OFF_ARMED = 1;
    localparam int STAT_GAIN_DONE = 2;
    localparam int STAT_LINE_LSB  = 16;

    // offset address fields
    localparam int OFFA_SET_LSB   = 16;

    // stored offset sets
    localparam logic [1:0] NUM_SETS = 2'h3;

    // reset values and edge limit maximum
    localparam logic [31:0] GOALS_RST    = 32'h8080_8080;
    localparam logic [15:0] RATE_RST     = 16'h0100;
    localparam logic [10:0] EDGE_RST     = 11'h000;
    localparam logic [10:0] EDGE_MAX     = 11'h7F8;

    // parallax direction codes
    typedef enum logic [2:0] {
        PAR_OFF,
        PAR_START,
        PAR_END,
        PAR_BLUE,
        PAR_RED
    } lsc_parallax_type;

    // calibration sequencer
    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_WAIT,
        CAL_RUN
    } lsc_cal_type;

endpackage

// ### core/lsc_shift_line.sv
// variable delay line: sample from a chosen number of valid beats ago
// assumes shift never exceeds DEPTH; the parent clamps it
`timescale 1ns/1ps
`default_nettype none
module lsc_shift_line #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    input  wire logic         clock,     // system clock
    input  wire logic         arst_n,    // async reset, active low
    input  wire logic         in_valid,  // sample strobe
    input  wire logic [W-1:0] in_data,   // current sample
    input  wire logic [7:0]   shift,     // delay in samples
    output logic      [W-1:0] out_data   // delayed sample
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] hist;
    } lsc_hist_type;

    lsc_hist_type st_r;
    lsc_hist_type st_nxt;

    // shift the history on each valid sample
    always_comb begin
        st_nxt = st_r;
        if (in_valid) begin
            st_nxt.hist = {st_r.hist[DEPTH-2:0], in_data};
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // zero shift passes the current sample through
    always_comb begin
        if (shift == 8'h00) begin
            out_data = in_data;
        end else begin
            out_data = st_r.hist[shift - 8'h01];
        end
    end

endmodule
`default_nettype wire

// ### core/lsc_line_correct.sv
// line correction stage: offset and gain shading fix, parallax shift, edge colour fix
// assumes pixels synchronous to clock, one register bus master
// Contract
// R1: three offset sets, chosen by offset_set_choice
// R2: offsets applied after activate while offset_set_use
// R3: auto goal is whole-line mean per component
// R4: manual goal: gray or red/green/blue
// R5: activate calibrates; gains applied while gain_set_use
// R6: smoothing averages neighbour columns against dust
// R7: region limits gain fix to columns
// R8: software sets line rate ratio versus object
// R9: parallax direction off, start/end, blue/red
// R10: edge fix only above edge strength limit
// R11: edge strength limit spans 0 to 2040
// R12: realign sensor lines by pixel shift
`timescale 1ns/1ps
`default_nettype none
module lsc_line_correct #(
    parameter int COLS      = 256,
    parameter int MAX_SHIFT = 16
) (
    input  wire logic        clock,            // 125 MHz clock
    input  wire logic        arst_n,           // async reset, active low
    input  wire logic [3:0]  avs_address,      // register word address
    input  wire logic        avs_read,         // read request
    input  wire logic        avs_write,        // write request
    input  wire logic [31:0] avs_writedata,    // write data
    output logic      [31:0] avs_readdata,     // read data
    output logic             avs_waitrequest,  // stall
    input  wire logic        in_valid,         // input pixel strobe
    input  wire logic        in_sol,           // first pixel of line
    input  wire logic [23:0] in_data,          // {r,g,b} pixel
    output logic             out_valid,        // output pixel strobe
    output logic             out_sol,          // first pixel of line
    output logic      [23:0] out_data          // corrected {r,g,b}
);

    localparam int COL_W = $clog2(COLS);
    localparam int SUM_W = COL_W + 8;

    typedef struct packed {
        logic                       bus_wait;
        logic [31:0]                rdata;
        logic                       off_use;
        logic                       gain_use;
        logic                       manual;
        logic                       smooth;
        logic                       region_on;
        logic                       edge_on;
        logic                       colour;
        logic [1:0]                 set_sel;
        logic [31:0]                goals;
        logic [15:0]                reg_left;
        logic [15:0]                reg_width;
        logic [10:0]                edge_lim;
        lsc_pkg::lsc_parallax_type  pdir;
        logic [7:0]                 pshift;
        logic [15:0]                rate_ratio;
        logic [1:0]                 wr_set;
        logic [15:0]                wr_col;
        logic                       off_armed;
        logic                       gain_done;
        lsc_pkg::lsc_cal_type       cal;
        logic [23:0]                cal_prev;
        logic [2:0][SUM_W-1:0]      sum;
        logic [2:0][7:0]            mean;
        logic [15:0]                line_cnt;
        logic [COL_W-1:0]           col_cnt;
        logic                       s1_v;
        logic                       s1_sol;
        logic [COL_W-1:0]           s1_col;
        logic [23:0]                s1_pix;
        logic                       s2_v;
        logic                       s2_sol;
        logic [23:0]                s2_pix;
        logic [7:0]                 prev_g;
        logic                       o_v;
        logic                       o_sol;
        logic [23:0]                o_pix;
    } lsc_state_type;

    lsc_state_type st_r;
    lsc_state_type st_nxt;

    logic [7:0]       off_mem [0:2][0:COLS-1];
    logic [23:0]      lvl_mem [0:COLS-1];
    logic [COL_W-1:0] col_now;
    logic [23:0]      lvl_wdata;
    logic             cap;
    logic             off_we;
    logic [15:0]      hist_out;

    // half sum of two components
    function automatic logic [7:0] avg8(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[8:1];
    endfunction

    // offset subtract then gain step, both saturating
    function automatic logic [7:0] fix_comp(input logic [7:0] p,
                                            input logic [7:0] off,
                                            input logic [7:0] goal,
                                            input logic [7:0] lvl,
                                            input logic       do_off,
                                            input logic       do_gain);
        logic signed [10:0] v;
        v = $signed({3'h0, p});
        if (do_off) begin
            v = v - $signed({3'h0, off});
            if (v[10]) begin
                v = 11'sh000;
            end
        end
        if (do_gain) begin
            v = v + $signed({3'h0, goal}) - $signed({3'h0, lvl});
        end
        if (v[10]) begin
            return 8'h00;
        end else if (v > 11'sh0FF) begin
            return 8'hFF;
        end
        return v[7:0];
    endfunction

    // column of the incoming pixel and calibration sample
    assign col_now = in_sol ? '0 : st_r.col_cnt;
    assign cap     = in_valid && ((st_r.cal == lsc_pkg::CAL_WAIT && in_sol)
                                  || st_r.cal == lsc_pkg::CAL_RUN);
    assign lvl_wdata = (st_r.smooth && !in_sol)
                     ? {avg8(in_data[23:16], st_r.cal_prev[23:16]),
                        avg8(in_data[15:8],  st_r.cal_prev[15:8]),
                        avg8(in_data[7:0],   st_r.cal_prev[7:0])}
                     : in_data;                                       // see R6
    assign off_we = avs_write && !st_r.bus_wait && avs_address == lsc_pkg::REG_OFF_DATA
                    && st_r.wr_set < lsc_pkg::NUM_SETS;

    // history of red and blue for realignment
    lsc_shift_line #(.W(16), .DEPTH(MAX_SHIFT)) u_shift (
        .clock    (clock),
        .arst_n   (arst_n),
        .in_valid (st_r.s2_v),
        .in_data  ({st_r.s2_pix[23:16], st_r.s2_pix[7:0]}),
        .shift    (st_r.pshift),
        .out_data (hist_out)
    );

    // next state: bus, calibration and pixel pipeline
    always_comb begin
        logic [7:0]  gsel [0:2];
        logic [7:0]  r_v;
        logic [7:0]  g_v;
        logic [7:0]  b_v;
        logic [7:0]  dg;
        logic        in_reg;
        logic        do_gain;
        logic [15:0] col16;
        logic [23:0] lvl;
        logic [SUM_W-1:0] base;
        st_nxt = st_r;
        gsel[0] = 8'h00;
        gsel[1] = 8'h00;
        gsel[2] = 8'h00;
        r_v = 8'h00;
        g_v = 8'h00;
        b_v = 8'h00;
        dg = 8'h00;
        col16 = 16'(st_r.s1_col);
        lvl = lvl_mem[st_r.s1_col];
        base = '0;

        // one wait cycle, then waitrequest low for one
        st_nxt.bus_wait = !((avs_read || avs_write) && st_r.bus_wait);
        if (avs_read && st_r.bus_wait) begin
            unique case (avs_address)
                lsc_pkg::REG_CTRL: st_nxt.rdata = {22'h0, st_r.set_sel, 1'b0, st_r.colour,
                    st_r.edge_on, st_r.region_on, st_r.smooth, st_r.manual,
                    st_r.gain_use, st_r.off_use};
                lsc_pkg::REG_GOALS:    st_nxt.rdata = st_r.goals;
                lsc_pkg::REG_REGION:   st_nxt.rdata = {st_r.reg_width, st_r.reg_left};
                lsc_pkg::REG_EDGE:     st_nxt.rdata = {21'h0, st_r.edge_lim};
                lsc_pkg::REG_PARALLAX: st_nxt.rdata = {16'h0, st_r.pshift, 5'h0, st_r.pdir};
                lsc_pkg::REG_RATE:     st_nxt.rdata = {16'h0, st_r.rate_ratio};
                lsc_pkg::REG_OFF_ADDR: st_nxt.rdata = {14'h0, st_r.wr_set, st_r.wr_col};
                lsc_pkg::REG_STATUS:   st_nxt.rdata = {st_r.line_cnt, 13'h0, st_r.gain_done,
                    st_r.off_armed, st_r.cal != lsc_pkg::CAL_IDLE};
                default:               st_nxt.rdata = 32'h0;
            endcase
        end

        // calibration capture
        if (in_valid) begin
            st_nxt.col_cnt = col_now + 1'b1;
        end
        if (cap) begin
            st_nxt.cal = lsc_pkg::CAL_RUN;
            st_nxt.cal_prev = in_data;
            for (int c = 0; c < 3; c++) begin
                base = in_sol ? '0 : st_r.sum[c];
                st_nxt.sum[c] = base + SUM_W'(lvl_wdata[c*8 +: 8]);
                st_nxt.mean[c] = st_nxt.sum[c][SUM_W-1:COL_W];       // see R3
            end
            if (col_now == COL_W'(COLS - 1)) begin
                st_nxt.cal = lsc_pkg::CAL_IDLE;
                st_nxt.gain_done = 1'b1;
            end
        end

        // stage 1: take pixel and its column
        st_nxt.s1_v = in_valid;
        if (in_valid) begin
            st_nxt.s1_sol = in_sol;
            st_nxt.s1_col = col_now;
            st_nxt.s1_pix = in_data;
        end

        // stage 2: offset and gain shading fix
        in_reg = !st_r.region_on || (col16 >= st_r.reg_left
                 && col16 - st_r.reg_left < st_r.reg_width);           // see R7
        do_gain = st_r.gain_use && st_r.gain_done && in_reg;           // see R5
        for (int c = 0; c < 3; c++) begin
            if (!st_r.manual) begin
                gsel[c] = st_r.mean[c];                                // see R3
            end else if (st_r.colour) begin
                gsel[c] = st_r.goals[8 + c*8 +: 8];                    // see R4
            end else begin
                gsel[c] = st_r.goals[7:0];                             // see R4
            end
        end
        st_nxt.s2_v = st_r.s1_v;
        if (st_r.s1_v) begin
            st_nxt.s2_sol = st_r.s1_sol;
            for (int c = 0; c < 3; c++) begin
                st_nxt.s2_pix[c*8 +: 8] = fix_comp(st_r.s1_pix[c*8 +: 8],
                    off_mem[st_r.set_sel][st_r.s1_col], gsel[c], lvl[c*8 +: 8],
                    st_r.off_use && st_r.off_armed, do_gain);          // see R1 R2
            end
        end

        // stage 3: realign red or blue line, then edge colour fix
        r_v = st_r.s2_pix[23:16];
        g_v = st_r.s2_pix[15:8];
        b_v = st_r.s2_pix[7:0];
        unique case (st_r.pdir)
            lsc_pkg::PAR_START, lsc_pkg::PAR_BLUE: r_v = hist_out[15:8]; // see R9 R12
            lsc_pkg::PAR_END, lsc_pkg::PAR_RED:    b_v = hist_out[7:0];  // see R9 R12
            default: ;                                                 // off or unused code
        endcase
        dg = (g_v > st_r.prev_g) ? g_v - st_r.prev_g : st_r.prev_g - g_v;
        if (st_r.s2_sol) begin
            dg = 8'h00;
        end
        if (st_r.edge_on && st_r.colour && {dg, 3'h0} > st_r.edge_lim) begin
            r_v = g_v;                                                 // see R10
            b_v = g_v;
        end
        st_nxt.o_v = st_r.s2_v;
        if (st_r.s2_v) begin
            st_nxt.o_sol = st_r.s2_sol;
            st_nxt.o_pix = {r_v, g_v, b_v};
            st_nxt.prev_g = g_v;
            if (st_r.s2_sol) begin
                st_nxt.line_cnt = st_r.line_cnt + 16'h0001;
            end
        end

        // writes land at the edge waitrequest is low
        if (avs_write && !st_r.bus_wait) begin
            unique case (avs_address)
                lsc_pkg::REG_CTRL: begin
                    st_nxt.off_use   = avs_writedata[lsc_pkg::CTRL_OFF_USE];
                    st_nxt.gain_use  = avs_writedata[lsc_pkg::CTRL_GAIN_USE];
                    st_nxt.manual    = avs_writedata[lsc_pkg::CTRL_MANUAL];
                    st_nxt.smooth    = avs_writedata[lsc_pkg::CTRL_SMOOTH];
                    st_nxt.region_on = avs_writedata[lsc_pkg::CTRL_REGION_ON];
                    st_nxt.edge_on   = avs_writedata[lsc_pkg::CTRL_EDGE_ON];
                    st_nxt.colour    = avs_writedata[lsc_pkg::CTRL_COLOUR];
                    if (avs_writedata[lsc_pkg::CTRL_SET_LSB +: 2] < lsc_pkg::NUM_SETS) begin
                        st_nxt.set_sel = avs_writedata[lsc_pkg::CTRL_SET_LSB +: 2]; // see R1
                    end
                    if (avs_writedata[lsc_pkg::CTRL_ACTIVATE]) begin
                        st_nxt.off_armed = 1'b1;                       // see R2
                        st_nxt.gain_done = 1'b0;                       // see R5
                        st_nxt.cal = lsc_pkg::CAL_WAIT;
                    end
                end
                lsc_pkg::REG_GOALS:  st_nxt.goals = avs_writedata;
                lsc_pkg::REG_REGION: begin
                    st_nxt.reg_left  = avs_writedata[15:0];
                    st_nxt.reg_width = avs_writedata[31:16];
                end
                lsc_pkg::REG_EDGE: begin
                    st_nxt.edge_lim = (avs_writedata > 32'(lsc_pkg::EDGE_MAX))
                        ? lsc_pkg::EDGE_MAX : avs_writedata[10:0];     // see R11
                end
                lsc_pkg::REG_PARALLAX: begin
                    if (avs_writedata[2:0] <= 3'(lsc_pkg::PAR_RED)) begin
                        st_nxt.pdir = lsc_pkg::lsc_parallax_type'(avs_writedata[2:0]);
                    end
                    st_nxt.pshift = (avs_writedata[15:8] > 8'(MAX_SHIFT))
                        ? 8'(MAX_SHIFT) : avs_writedata[15:8];
                end
                lsc_pkg::REG_RATE:     st_nxt.rate_ratio = avs_writedata[15:0]; // see R8
                lsc_pkg::REG_OFF_ADDR: begin
                    st_nxt.wr_col = avs_writedata[15:0];
                    st_nxt.wr_set = avs_writedata[lsc_pkg::OFFA_SET_LSB +: 2];
                end
                lsc_pkg::REG_OFF_DATA: st_nxt.wr_col = st_r.wr_col + 16'h0001;
                default: ;
            endcase
        end
    end

    // state register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_r            <= '0;
            st_r.bus_wait   <= 1'b1;
            st_r.goals      <= lsc_pkg::GOALS_RST;
            st_r.rate_ratio <= lsc_pkg::RATE_RST;
            st_r.edge_lim   <= lsc_pkg::EDGE_RST;
            st_r.pdir       <= lsc_pkg::PAR_OFF;
            st_r.cal        <= lsc_pkg::CAL_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // offset and level tables
    always_ff @(posedge clock) begin
        if (off_we) begin
            off_mem[st_r.wr_set][st_r.wr_col[COL_W-1:0]] <= avs_writedata[7:0];
        end
        if (cap) begin
            lvl_mem[col_now] <= lvl_wdata;
        end
    end

    assign avs_readdata    = st_r.rdata;
    assign avs_waitrequest = st_r.bus_wait;
    assign out_valid       = st_r.o_v;
    assign out_sol         = st_r.o_sol;
    assign out_data        = st_r.o_pix;

endmodule
`default_nettype wire

// ### test/lsc_line_correct_properties.sv
// checker: bus handshake, field limits, pixel timing
// assumes binding to lsc_line_correct ports
`timescale 1ns/1ps
`default_nettype none
module lsc_line_correct_chk #(
    parameter int COLS      = 256,
    parameter int MAX_SHIFT = 16
) (
    input wire logic        clock, // clock
    input wire logic        arst_n, // reset, low
    input wire logic [3:0]  avs_address, // address
    input wire logic        avs_read, // read
    input wire logic        avs_write, // write
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [31:0] avs_readdata, // read data
    input wire logic        avs_waitrequest, // stall
    input wire logic        in_valid, // in strobe
    input wire logic        in_sol, // in line start
    input wire logic [23:0] in_data, // in pixel
    input wire logic        out_valid, // out strobe
    input wire logic        out_sol, // out line start
    input wire logic [23:0] out_data // out pixel
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // a read taken this cycle, answered the next
    sequence rd_of(logic [3:0] a);
        avs_read && avs_waitrequest && avs_address == a;
    endsequence
    // bus handshake
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer");
    wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
    unmapped_zero_a: assert property (avs_read && avs_waitrequest && avs_address > 4'h8
        |=> avs_readdata == 32'h0) else $error("unmapped read");
    // field limits
    set_choice_a: assert property (rd_of(lsc_pkg::REG_CTRL) |=> avs_readdata[9:8] != 2'h3)
        else $error("set choice 3");
    act_clear_a: assert property (rd_of(lsc_pkg::REG_CTRL) |=> !avs_readdata[31])
        else $error("activate reads 1");
    edge_limit_a: assert property (rd_of(lsc_pkg::REG_EDGE) |=> avs_readdata <= 32'h7F8)
        else $error("edge limit");
    dir_code_a: assert property (rd_of(lsc_pkg::REG_PARALLAX) |=> avs_readdata[2:0] <= 3'h4)
        else $error("bad direction");
    shift_cap_a: assert property (rd_of(lsc_pkg::REG_PARALLAX)
        |=> avs_readdata[15:8] <= 8'(MAX_SHIFT)) else $error("shift limit");
    // pixel stream timing
    pix_latency_a: assert property (in_valid |-> ##3 out_valid && out_sol == $past(in_sol, 3))
        else $error("output late");
    pix_cause_a: assert property (out_valid |-> $past(in_valid, 3))
        else $error("stray output");
    pix_hold_a: assert property (!out_valid |-> $stable(out_data) && $stable(out_sol))
        else $error("output moved");
    cover property (rd_of(lsc_pkg::REG_STATUS) ##1 avs_readdata[2]);
    cover property (out_valid && out_sol);
    cover property (in_valid ##1 in_valid);
endmodule
bind lsc_line_correct lsc_line_correct_chk #(.COLS(COLS), .MAX_SHIFT(MAX_SHIFT)) chk_i (
    .clock(clock), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_valid(in_valid), .in_sol(in_sol),
    .in_data(in_data), .out_valid(out_valid), .out_sol(out_sol), .out_data(out_data));
`default_nettype wire

// ### test/lsc_pix_src.sv
// sensor model: one line of 16 pixels with gaps
// assumes the bench calls send_line
`timescale 1ns/1ps
`default_nettype none
module lsc_pix_src (
    input  wire logic        clock,     // system clock
    output logic             in_valid,  // pixel strobe
    output logic             in_sol,    // first pixel of line
    output logic      [23:0] in_data    // pixel value
);
    initial {in_valid, in_sol, in_data} = '0;
    // gap after odd columns; data inverted while idle
    task automatic send_line(input logic [23:0] px [16]);
        for (int c = 0; c < 16; c++) begin
            @(posedge clock);
            in_valid <= 1'b1;
            in_sol   <= (c == 0);
            in_data  <= px[c];
            if (c % 2 == 1) begin
                @(posedge clock);
                in_valid <= 1'b0;
                in_data  <= ~px[c];
            end
        end
    endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// bench: register access and corrected lines
// assumes 16 columns and the pixel source model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest, in_valid, in_sol, out_valid, out_sol;
    logic [23:0] in_data, out_data;
    logic [23:0] line_in [16], line_exp [16], got [16];
    int          n_fail = 0, total_checks = 0, cycles = 0, idx = 0;
    always #4 clock = ~clock;
    lsc_pix_src lsc_pix_src_i (.clock(clock), .in_valid(in_valid), .in_sol(in_sol),
        .in_data(in_data));
    lsc_line_correct #(.COLS(16), .MAX_SHIFT(16)) lsc_line_correct_i (
        .clock(clock), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .in_valid(in_valid), .in_sol(in_sol),
        .in_data(in_data), .out_valid(out_valid), .out_sol(out_sol), .out_data(out_data));
    // capture output line by column; hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            test_done();
        end
        if (out_valid === 1'b1) begin
            idx = (out_sol === 1'b1) ? 0 : idx + 1;
            got[idx[3:0]] = out_data;
        end
    end
    task automatic test_done();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t reg %h exp %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        bus(1'b0, a, 32'h0);
        chk_reg(rd & m, e);
    endtask
    // send line_in, compare columns lo..hi
    task automatic run_line(input int lo, input int hi);
        foreach (got[c]) got[c] = 'x;
        lsc_pix_src_i.send_line(line_in);
        repeat (6) @(posedge clock);
        for (int c = lo; c <= hi; c++) begin
            total_checks++;
            if (got[c] !== line_exp[c]) begin
                n_fail++;
                $display("ERROR %0t col %0d %h exp %h", $time, c, got[c], line_exp[c]);
            end
        end
    endtask
    initial begin
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        rchk(lsc_pkg::REG_GOALS, lsc_pkg::GOALS_RST);
        rchk(lsc_pkg::REG_STATUS, 32'h0, 32'h7);
        rchk(4'hC, 32'h0);
        wr(lsc_pkg::REG_RATE, 32'h0100);
        wr(lsc_pkg::REG_EDGE, 32'h7FF);
        rchk(lsc_pkg::REG_EDGE, {21'h0, lsc_pkg::EDGE_MAX});
        wr(lsc_pkg::REG_PARALLAX, 32'h1405);
        rchk(lsc_pkg::REG_PARALLAX, 32'h1000);
        // every direction code, shift of two
        for (int k = 0; k < 5; k++) begin
            wr(lsc_pkg::REG_PARALLAX, 32'h200 | k);
            for (int c = 0; c < 16; c++) begin
                line_in[c] = {8'(c), 8'h80, 8'(192 + c)};
                line_exp[c] = {8'((k == 1 || k == 3) ? c - 2 : c), 8'h80,
                               8'(192 + ((k == 2 || k == 4) ? c - 2 : c))};
            end
            run_line(2, 15);
        end
        wr(lsc_pkg::REG_PARALLAX, 32'h0);
        // edge fix above and at the limit
        wr(lsc_pkg::REG_CTRL, 32'h60);
        for (int k = 127; k < 129; k++) begin
            wr(lsc_pkg::REG_EDGE, k);
            for (int c = 0; c < 16; c++) begin
                line_in[c] = {8'h10, (c < 8) ? 8'h40 : 8'h50, 8'h90};
                line_exp[c] = (c == 8 && k == 127) ? 24'h505050 : line_in[c];
            end
            run_line(0, 15);
        end
        // offset set one holds the column number
        wr(lsc_pkg::REG_CTRL, 32'h101);
        wr(lsc_pkg::REG_OFF_ADDR, 32'h10000);
        for (int c = 0; c < 16; c++) wr(lsc_pkg::REG_OFF_DATA, c);
        wr(lsc_pkg::REG_CTRL, 32'h301);
        rchk(lsc_pkg::REG_CTRL, 32'h101);
        foreach (line_in[c]) line_in[c] = 24'h080305;
        line_exp = line_in;
        run_line(0, 15);
        wr(lsc_pkg::REG_CTRL, 32'h80000101);
        rchk(lsc_pkg::REG_CTRL, 32'h101);
        for (int c = 0; c < 16; c++)
            line_exp[c] = {8'((c < 8) ? 8 - c : 0), 8'((c < 3) ? 3 - c : 0), 8'((c < 5) ? 5 - c : 0)};
        run_line(0, 15);
        // manual goals: calibrate, then correct
        wr(lsc_pkg::REG_GOALS, 32'h40506070);
        wr(lsc_pkg::REG_CTRL, 32'h80000046);
        foreach (line_in[c]) line_in[c] = {8'(c + 10), 8'(c + 20), 8'(c + 30)};
        run_line(0, -1);
        rchk(lsc_pkg::REG_STATUS, 32'h6, 32'h7);
        foreach (line_exp[c]) line_exp[c] = 24'h405060;
        run_line(0, 15);
        wr(lsc_pkg::REG_CTRL, 32'h06);
        foreach (line_exp[c]) line_exp[c] = 24'h707070;
        run_line(0, 15);
        wr(lsc_pkg::REG_REGION, 32'h00040004);
        wr(lsc_pkg::REG_CTRL, 32'h56);
        foreach (line_exp[c]) line_exp[c] = (c >= 4 && c < 8) ? 24'h405060 : line_in[c];
        run_line(0, 15);
        wr(lsc_pkg::REG_CTRL, 32'h44);
        line_exp = line_in;
        run_line(0, 15);
        // automatic goal: column means 17, 27 and 37
        wr(lsc_pkg::REG_CTRL, 32'h80000042);
        run_line(0, -1);
        foreach (line_exp[c]) line_exp[c] = 24'h111B25;
        run_line(0, 15);
        wr(lsc_pkg::REG_CTRL, 32'h8000004A);
        run_line(0, -1);
        run_line(1, 15);
        test_done();
    end
endmodule
`default_nettype wire
